// [pkg/cmp_ctl_pkg.sv]
// Constants and types for the dual comparator control and change interrupt block
package cmp_ctl_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL0    = 8'h00;  // First comparator control
    localparam logic [7:0] OFS_CTRL1    = 8'h04;  // Second comparator control
    localparam logic [7:0] OFS_AUX      = 8'h08;  // Second comparator auxiliary control
    localparam logic [7:0] OFS_FLAG     = 8'h0C;  // Peripheral flag register two
    localparam logic [7:0] OFS_IRQ_EN   = 8'h10;  // Peripheral enable register two
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h14;  // Global and peripheral enables

    // Control register field positions
    localparam int POS_ENABLE = 7;
    localparam int POS_RESULT = 6;
    localparam int POS_PIN_OE = 5;
    localparam int POS_POL    = 4;
    localparam int POS_REF    = 2;
    localparam int POS_SEL    = 0;

    // Auxiliary register field positions
    localparam int POS_MIRROR0   = 7;
    localparam int POS_MIRROR1   = 6;
    localparam int POS_GATE_SRC  = 1;
    localparam int POS_GATE_SYNC = 0;

    // Interrupt control field positions
    localparam int POS_GIE  = 7;
    localparam int POS_PERIPHERAL_IRQ_ENABLE = 6;

    // Values after reset
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_AUX  = 8'h00;
    localparam logic       RST_LAT  = 1'b0;

    // Instruction cycle length in clock cycles
    localparam int INSTR_CYCLE_CLOCKS = 4;

    // Stored fields of one comparator control register
    typedef struct packed {
        logic       enable;
        logic       pin_output_enable;
        logic       polarity;
        logic       reference_select;
        logic [1:0] inverting_input_select;
    } cmp_cfg_t;

endpackage : cmp_ctl_pkg

// [hw/cmp_ctl.sv]
// Dual comparator control, output latching and change interrupt logic
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

module cmp_ctl #(
    parameter int NUM_CMP = 2  // Comparators in the block
) (
    input  wire logic                    mclk,               // 125 MHz clock
    input  wire logic                    rst_n,              // Synchronous reset
    // Wishbone classic slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // Analog front end
    input  wire logic [NUM_CMP-1:0]      cmp_raw,            // Raw plus-above-minus
    output logic      [NUM_CMP-1:0]      cmp_power,          // Comparator enable
    output logic      [2*NUM_CMP-1:0]    inverting_input_sel,
    output logic      [NUM_CMP-1:0]      reference_sel,
    // Port pins
    input  wire logic [NUM_CMP-1:0]      pin_direction,      // One means input
    output logic      [NUM_CMP-1:0]      pin_override,
    output logic      [NUM_CMP-1:0]      pin_out,
    output logic      [NUM_CMP-1:0]      pin_oe,
    // First timer link, second comparator only
    output logic                         timer_gate,
    output logic                         timer_gate_src,
    output logic                         timer_gate_sync,
    // Interrupt request and wake
    output logic                         irq,
    output logic                         wake
);

    // Instruction cycle phase counter
    logic [1:0] phase;
    wire        first_clock_phase = (phase == 2'h0);

    // Bus request decode
    wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_req   = req & wb_we_i & wb_sel_i[0];
    wire        rd_req   = req & ~wb_we_i;
    wire        hit_aux  = (wb_adr_i == cmp_ctl_pkg::OFS_AUX);
    wire        hit_flag = (wb_adr_i == cmp_ctl_pkg::OFS_FLAG);
    wire        hit_ien  = (wb_adr_i == cmp_ctl_pkg::OFS_IRQ_EN);
    wire        hit_ictl = (wb_adr_i == cmp_ctl_pkg::OFS_IRQ_CTRL);

    // Shared registers
    logic [7:0]         aux;            // Auxiliary control, timer link bits
    logic [NUM_CMP-1:0] irq_flag;       // Sticky change flags
    logic [NUM_CMP-1:0] irq_enable;     // Per comparator enables
    logic               peripheral_irq_enable;
    logic               global_irq_enable;

    // Per comparator state gathered for the read mux and the flag logic
    logic [NUM_CMP-1:0] result;         // Instruction-latched output
    logic [NUM_CMP-1:0] mismatch_rise;
    logic [7:0]         ctrl_rd [NUM_CMP];
    logic [NUM_CMP-1:0] hit_ctrl;

    // Control register offset for comparator index
    function automatic logic [7:0] ctrl_ofs(input int idx);
        ctrl_ofs = (idx == 0) ? cmp_ctl_pkg::OFS_CTRL0 : cmp_ctl_pkg::OFS_CTRL1;
    endfunction : ctrl_ofs

    // Instruction cycle divider gives the first phase enable
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            phase <= 2'h0;
        else if (phase == 2'(cmp_ctl_pkg::INSTR_CYCLE_CLOCKS - 1))
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++)
        begin : gen_cmp
            cmp_ctl_pkg::cmp_cfg_t cfg;     // Stored control fields
            logic sync_a;                   // First synchroniser stage
            logic sync_b;                   // Second synchroniser stage
            logic cycle_lat;                // Latch sampled each first phase
            logic snap_lat;                 // Latch refreshed by register access
            logic mismatch_prev;            // For edge detection
            logic pin_val;                  // Registered pin value

            wire hit   = (wb_adr_i == ctrl_ofs(g));
            // A write starts with an internal read, so both refresh the snapshot
            wire touch = (rd_req | (req & wb_we_i)) & hit;
            // Disabled comparator yields a low raw decision
            wire raw   = sync_b & cfg.enable;
            wire pol_v = raw ^ cfg.polarity;
            // Mismatch is the xor of the two latches; OE plays no part
            wire mismatch = snap_lat ^ cycle_lat;

            assign hit_ctrl[g]      = hit;
            assign result[g]        = cycle_lat;
            assign mismatch_rise[g] = mismatch & ~mismatch_prev;
            assign ctrl_rd[g] = {cfg.enable, cycle_lat, cfg.pin_output_enable,
                                 cfg.polarity, 1'b0, cfg.reference_select,
                                 cfg.inverting_input_select};

            // Control fields; reset leaves the comparator off
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    cfg <= cmp_ctl_pkg::cmp_cfg_t'({cmp_ctl_pkg::RST_CTRL[7],
                           cmp_ctl_pkg::RST_CTRL[5:4], cmp_ctl_pkg::RST_CTRL[2:0]});
                else if (wr_req & hit)
                begin
                    cfg.enable                 <= wb_dat_i[cmp_ctl_pkg::POS_ENABLE];
                    cfg.pin_output_enable      <= wb_dat_i[cmp_ctl_pkg::POS_PIN_OE];
                    cfg.polarity               <= wb_dat_i[cmp_ctl_pkg::POS_POL];
                    cfg.reference_select       <= wb_dat_i[cmp_ctl_pkg::POS_REF];
                    cfg.inverting_input_select <= wb_dat_i[cmp_ctl_pkg::POS_SEL +: 2];
                end
            end

            // Raw analog decision is asynchronous, so two stages first
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    sync_a <= 1'b0;
                    sync_b <= 1'b0;
                end
                else
                begin
                    sync_a <= cmp_raw[g];
                    sync_b <= sync_a;
                end
            end

            // Both latches reset alike so enabling gives no false change
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    cycle_lat     <= cmp_ctl_pkg::RST_LAT;
                    snap_lat      <= cmp_ctl_pkg::RST_LAT;
                    mismatch_prev <= 1'b0;
                end
                else
                begin
                    if (first_clock_phase)
                        cycle_lat <= pol_v;
                    // Held until the next access; output return also clears
                    if (touch)
                        snap_lat <= cycle_lat;
                    mismatch_prev <= mismatch;
                end
            end

            // Pin side is not held per instruction cycle, only retimed once
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    pin_val <= 1'b0;
                else
                    pin_val <= pol_v;
            end

            // Port override follows OE alone; drive needs all three conditions
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    pin_override[g] <= 1'b0;
                    pin_oe[g]       <= 1'b0;
                end
                else
                begin
                    pin_override[g] <= cfg.pin_output_enable;
                    pin_oe[g]       <= cfg.pin_output_enable & ~pin_direction[g]
                                       & cfg.enable;
                end
            end

            // Analog controls come straight from the stored fields
            assign cmp_power[g]                   = cfg.enable;
            assign inverting_input_sel[2*g +: 2]  = cfg.inverting_input_select;
            assign reference_sel[g]               = cfg.reference_select;
            assign pin_out[g]                     = pin_val;
        end
    endgenerate

    // Auxiliary register: timer link bits and mirrored results
    wire [7:0] aux_rd = {result[0], result[1], aux[5:0]};

    // Read data selection
    wire [7:0] rd_byte =
        hit_ctrl[0] ? ctrl_rd[0] :
        hit_ctrl[1] ? ctrl_rd[1] :
        hit_aux     ? aux_rd :
        hit_flag    ? {6'h00, irq_flag} :
        hit_ien     ? {6'h00, irq_enable} :
        hit_ictl    ? {global_irq_enable, peripheral_irq_enable, 6'h00} :
                      8'h00;

    // Shared registers; a hardware set wins over a software clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            aux                   <= cmp_ctl_pkg::RST_AUX;
            irq_flag              <= '0;
            irq_enable            <= '0;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable     <= 1'b0;
        end
        else
        begin
            if (wr_req & hit_aux)
                aux <= {2'h0, 4'h0, wb_dat_i[1:0]};
            if (wr_req & hit_flag)
                irq_flag <= wb_dat_i[NUM_CMP-1:0] | mismatch_rise;
            else
                irq_flag <= irq_flag | mismatch_rise;
            if (wr_req & hit_ien)
                irq_enable <= wb_dat_i[NUM_CMP-1:0];
            if (wr_req & hit_ictl)
            begin
                peripheral_irq_enable <= wb_dat_i[cmp_ctl_pkg::POS_PERIPHERAL_IRQ_ENABLE];
                global_irq_enable     <= wb_dat_i[cmp_ctl_pkg::POS_GIE];
            end
        end
    end

    // Bus answer one cycle after the request is taken
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h000000, rd_byte} : '0;
        end
    end

    // Interrupt and wake gating; flags stand regardless of enables
    wire pending = |(irq_flag & irq_enable);
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            irq  <= pending & peripheral_irq_enable & global_irq_enable;
            wake <= pending & peripheral_irq_enable;
        end
    end

    // Only the second comparator reaches the first timer
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            timer_gate      <= 1'b0;
            timer_gate_src  <= 1'b0;
            timer_gate_sync <= 1'b0;
        end
        else
        begin
            timer_gate      <= result[1];
            timer_gate_src  <= aux[cmp_ctl_pkg::POS_GATE_SRC];
            timer_gate_sync <= aux[cmp_ctl_pkg::POS_GATE_SYNC];
        end
    end

endmodule : cmp_ctl

// [dv/cmp_ctl_chk.sv]
// Port-level assertion checker for the comparator control block
`timescale 1ns/1ps
module cmp_ctl_chk #(
    parameter int NUM_CMP = 2  // Comparators watched
) (
    input wire logic               mclk,
    input wire logic               rst_n,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic [NUM_CMP-1:0] cmp_power,
    input wire logic [NUM_CMP-1:0] pin_direction,
    input wire logic [NUM_CMP-1:0] pin_override,
    input wire logic [NUM_CMP-1:0] pin_oe,
    input wire logic               irq,
    input wire logic               wake
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    chk_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data present without ack");
    chk_data_upper: assert property (wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    // Either output latency of the enable is accepted, the direction is one flop old
    chk_pin_drive: assert property ((pin_oe & ~(cmp_power | $past(cmp_power))) == '0 && (pin_oe & $past(pin_direction)) == '0)
        else $error("pin driven without enable or with input direction");
    chk_pin_override: assert property ((pin_oe & ~pin_override) == '0)
        else $error("pin driven without port override");
    chk_irq_wake: assert property (irq |-> wake)
        else $error("interrupt without wake condition");
    chk_reset_off: assert property ($rose(rst_n) |-> cmp_power == '0 && !irq && pin_oe == '0)
        else $error("outputs active right after reset");
endmodule : cmp_ctl_chk

bind cmp_ctl cmp_ctl_chk #(.NUM_CMP(NUM_CMP)) cmp_ctl_chk_i (.mclk(mclk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmp_power(cmp_power), .pin_direction(pin_direction), .pin_override(pin_override),
    .pin_oe(pin_oe), .irq(irq), .wake(wake));

// [dv/analog_front.sv]
// Behavioural analog front end feeding raw comparator decisions
`timescale 1ns/1ps
module analog_front (
    input  wire logic       mclk,        // Block clock, scrambles idle output
    input  wire logic [1:0] plus_above,  // Commanded input relation
    input  wire logic [1:0] cmp_power,   // Comparator enable from the block
    output logic      [1:0] cmp_raw      // Raw decision to the block
);
    logic [1:0] idle_pat = 2'h1;  // Pattern of an unpowered comparator
    // An unpowered comparator gives no valid decision, so toggle rather than hold
    always_ff @(posedge mclk)
    begin
        idle_pat <= ~idle_pat;
    end
    // Powered comparator follows its inputs
    assign cmp_raw = (cmp_power & plus_above) | (~cmp_power & idle_pat);
endmodule : analog_front

// [dv/cmp_ctl_test.sv]
// Self-checking testbench for the dual comparator control block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("[ERR] %0t got %h exp %h", $time, got, exp); \
        end \
    end
module cmp_ctl_test;
    localparam logic [7:0] A_C0  = cmp_ctl_pkg::OFS_CTRL0;     // Control, first
    localparam logic [7:0] A_C1  = cmp_ctl_pkg::OFS_CTRL1;     // Control, second
    localparam logic [7:0] A_AUX = cmp_ctl_pkg::OFS_AUX;       // Auxiliary
    localparam logic [7:0] A_FLG = cmp_ctl_pkg::OFS_FLAG;      // Flags
    localparam logic [7:0] A_IEN = cmp_ctl_pkg::OFS_IRQ_EN;    // Own enables
    localparam logic [7:0] A_ICT = cmp_ctl_pkg::OFS_IRQ_CTRL;  // Global enables
    logic        mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [1:0]  plus_above, cmp_raw, cmp_power, pin_direction, pin_override, pin_out, pin_oe;
    logic [3:0]  inv_sel;
    logic [1:0]  ref_sel;
    logic        timer_gate, gate_src, gate_sync, irq, wake, r1;
    int          n_mismatch, n_tests, cycles;

    cmp_ctl cmp_ctl_i (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_raw(cmp_raw), .cmp_power(cmp_power),
        .inverting_input_sel(inv_sel), .reference_sel(ref_sel), .pin_direction(pin_direction),
        .pin_override(pin_override), .pin_out(pin_out), .pin_oe(pin_oe),
        .timer_gate(timer_gate), .timer_gate_src(gate_src), .timer_gate_sync(gate_sync),
        .irq(irq), .wake(wake));
    analog_front analog_front_i (.mclk(mclk), .plus_above(plus_above), .cmp_power(cmp_power),
        .cmp_raw(cmp_raw));

    // Free-running 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // One classic cycle; request held until ack is sampled, then one idle cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                        output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, wd};
        @(posedge mclk);
        while (wb_ack_o !== 1'b1)
            @(posedge mclk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask : xfer

    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [31:0] d;
        xfer(1'b1, adr, wd, d);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, adr, 8'h00, d);
        `CHK(d, {24'h00_0000, exp})
    endtask : rd

    // Enough for two sync flops plus a full instruction cycle
    task automatic settle();
        repeat (8) @(posedge mclk);
    endtask : settle

    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, rst_n} = 4'h0;
        {wb_adr_i, wb_dat_i, plus_above} = '0;
        {n_mismatch, n_tests, cycles} = '0;
        wb_sel_i = 4'hF;
        pin_direction = 2'h3;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        // Reset values, plus two unmapped holes reading zero
        foreach (A_C0[i]) rd(8'(i * 4), 8'h00);
        `CHK(cmp_power, 2'h0)
        // Every select code on both comparators, opposite reference choices
        for (int i = 0; i < 4; i++)
        begin
            wr(A_C0, 8'h80 | 8'(i) | (i[0] ? 8'h04 : 8'h00));
            wr(A_C1, 8'h80 | 8'(3 - i) | (i[0] ? 8'h00 : 8'h04));
            `CHK(inv_sel, {2'(3 - i), 2'(i)})
            `CHK(ref_sel, {~i[0], i[0]})
            `CHK(cmp_power, 2'h3)
        end
        wr(A_C0, 8'h00);
        wr(A_C1, 8'h00);
        `CHK(cmp_power, 2'h0)
        // Polarity table with the two comparators deciding oppositely
        for (int i = 0; i < 4; i++)
        begin
            plus_above <= {i[0], ~i[0]};
            wr(A_C0, {3'h4, i[1], 4'h0});
            wr(A_C1, {3'h4, i[1], 4'h0});
            settle();
            r1 = i[0] ^ i[1];
            rd(A_C0, {1'b1, ~r1, 1'b0, i[1], 4'h0});
            rd(A_C1, {1'b1, r1, 1'b0, i[1], 4'h0});
            rd(A_AUX, {~r1, r1, 6'h00});
            `CHK(timer_gate, r1)
            `CHK(pin_out, {r1, ~r1})
        end
        // Pin drive needs output enable, output direction and comparator enable
        pin_direction <= 2'h0;
        wr(A_C0, 8'hA0);
        wr(A_C1, 8'h20);
        settle();
        `CHK(pin_oe, 2'h1)
        `CHK(pin_override, 2'h3)
        pin_direction <= 2'h3;
        settle();
        `CHK(pin_oe, 2'h0)
        // Change interrupts with the first pin override still set
        plus_above <= 2'h0;
        wr(A_C0, 8'hA0);
        wr(A_C1, 8'h00);
        settle();
        rd(A_C0, 8'hA0);
        wr(A_FLG, 8'h00);
        wr(A_IEN, 8'h01);
        wr(A_ICT, 8'h40);
        plus_above <= 2'h1;
        settle();
        rd(A_FLG, 8'h01);
        `CHK(wake, 1'b1)
        `CHK(irq, 1'b0)
        wr(A_FLG, 8'h00);
        settle();
        rd(A_FLG, 8'h00);
        plus_above <= 2'h0;
        settle();
        rd(A_FLG, 8'h00);
        plus_above <= 2'h1;
        settle();
        rd(A_FLG, 8'h01);
        wr(A_FLG, 8'h00);
        rd(A_C0, 8'hE0);
        plus_above <= 2'h0;
        settle();
        rd(A_FLG, 8'h01);
        // A write clears the pending mismatch, so the return to high flags again
        wr(A_FLG, 8'h00);
        wr(A_C0, 8'hA0);
        rd(A_FLG, 8'h00);
        plus_above <= 2'h1;
        settle();
        rd(A_FLG, 8'h01);
        wr(A_ICT, 8'hC0);
        settle();
        `CHK(irq, 1'b1)
        wr(A_IEN, 8'h00);
        settle();
        `CHK({irq, wake}, 2'h0)
        rd(A_FLG, 8'h01);
        wr(A_FLG, 8'h02);
        wr(A_IEN, 8'h02);
        settle();
        `CHK(irq, 1'b1)
        print_verdict();
    end
endmodule : cmp_ctl_test
